/* File: core/atf_decode.sv */
// Purpose: host-side register decode of a parallel disk interface
// Assumes: host holds chip selects, address and write data stable
//   around each strobe; firmware behind the block runs commands
// Notes: strobes are filtered, so an access lands some cycles late
`timescale 1ns/1ps
`default_nettype none
module atf_decode #(
	parameter logic [7:0] DIAG_CODE = 8'h90,
	parameter logic [7:0] DEV_RESET_CODE = 8'h08
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cs0_n,
	input wire logic cs1_n,
	input wire logic [2:0] da,
	input wire logic dior_n,
	input wire logic diow_n,
	input wire logic [15:0] dd_in,
	output logic [15:0] dd_out,
	output logic dd_oe_n,
	input wire logic dev_strap,
	output logic intrq_out,
	output logic intrq_oe_n,
	input wire logic pdiag_in_n,
	output logic pdiag_out_n,
	output logic pdiag_oe_n,
	input wire logic [7:0] fw_status,
	input wire logic fw_irq_set,
	input wire logic fw_param_taken,
	input wire logic fw_sleep,
	input wire logic fw_diag_pass,
	output logic cmd_start,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_cyl_lo,
	output logic [7:0] cmd_cyl_hi,
	output logic [7:0] cmd_dev_head,
	output logic cmd_diag_both,
	output logic soft_reset,
	output logic peer_diag_ok
);
	import atf_pkg::*;

	atf_pins_if pin_if ();

	atf_pin_sync u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.raw({pdiag_in_n, dev_strap, diow_n, dior_n}),
		.pins(pin_if)
	);

	logic [7:0] cyl_lo, cyl_hi, dev_head, dev_ctrl;
	logic busy_flag, irq_pend, peer_ok_q;
	atf_cmd_st_t cmd_st, next_cmd_st;

	// address decode against the raw pins, stable during a strobe
	wire [1:0] cs = {cs1_n, cs0_n};
	wire blk_cmd = (cs == CS_CMD);
	wire blk_ctl = (cs == CS_CTL);
	wire hit_ctl6 = atf_hit(cs, da, CS_CTL, OFF_ALT_STATUS);
	// both selects equal, or control block off 6h, selects nothing
	wire addr_ok = blk_cmd || hit_ctl6;
	wire hit_lo = atf_hit(cs, da, CS_CMD, OFF_CYL_LO);
	wire hit_hi = atf_hit(cs, da, CS_CMD, OFF_CYL_HI);
	wire hit_dh = atf_hit(cs, da, CS_CMD, OFF_DEV_HEAD);
	wire hit_cmd = atf_hit(cs, da, CS_CMD, OFF_COMMAND);

	// selection from the device select bit and the jumper
	wire selected = (dev_head[DEV_SEL_BIT] == pin_if.dev_id);

	// status byte, shared by status and alternate status
	wire busy = busy_flag | fw_status[BSY_BIT];
	wire [7:0] status_byte = {busy, fw_status[6:0]};

	// strobes on an invalid address are dropped here
	wire rd_ok = pin_if.rd_pulse && addr_ok;
	wire wr_ok = pin_if.wr_pulse && addr_ok;
	wire [7:0] wdata = dd_in[7:0];

	// command block writes, refused while busy
	wire cb_wr = wr_ok && blk_cmd && !busy;
	wire cmd_wr = wr_ok && hit_cmd;
	wire is_reset_cmd = (wdata == DEV_RESET_CODE);
	// only the device reset command gets past a busy drive
	wire cmd_take = cmd_wr && (!busy || is_reset_cmd);
	wire is_diag = (wdata == DIAG_CODE);
	// diagnostics aimed at device 0 runs on both drives
	wire diag_both = is_diag && !dev_head[DEV_SEL_BIT];
	wire cmd_exec = cmd_take && (selected || diag_both);
	wire ctl_wr = wr_ok && hit_ctl6;

	// an unselected drive leaves the bus to its partner
	wire rd_drive = rd_ok && selected;
	wire rd_stat = rd_ok && hit_cmd && selected;
	wire rd_alt = rd_ok && hit_ctl6;

	// read mux; the alternate status never touches irq_pend
	wire [7:0] rd_reg = hit_ctl6 ? status_byte :
		hit_cmd ? status_byte :
		hit_lo ? cyl_lo :
		hit_hi ? cyl_hi :
		hit_dh ? dev_head : RST_REG;
	// contents are not to be trusted in sleep, so show zero
	wire [7:0] rd_byte = fw_sleep ? RST_REG : rd_reg;

	// set wins over either clear, so no event is lost
	wire irq_clr = rd_stat || (cmd_take && selected);
	wire next_irq = fw_irq_set || (irq_pend && !irq_clr);

	// busy holds until firmware has taken the parameters
	always_comb begin
		next_cmd_st = cmd_st;
		case (cmd_st)
			ATF_IDLE: begin
				if (cmd_exec) begin
					next_cmd_st = ATF_HOLD;
				end
			end
			ATF_HOLD: begin
				if (fw_param_taken && !cmd_exec) begin
					next_cmd_st = ATF_IDLE;
				end
			end
			default: begin
				next_cmd_st = ATF_IDLE;
			end
		endcase
	end

	// command state and busy
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cmd_st <= ATF_IDLE;
			busy_flag <= 1'b0;
		end else begin
			cmd_st <= next_cmd_st;
			busy_flag <= (next_cmd_st == ATF_HOLD);
		end
	end

	// cylinder registers; a write while drq is set is simply taken
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cyl_lo <= RST_REG;
			cyl_hi <= RST_REG;
			dev_head <= RST_REG;
		end else begin
			if (cb_wr && hit_lo) begin
				cyl_lo <= wdata;
			end
			if (cb_wr && hit_hi) begin
				cyl_hi <= wdata;
			end
			if (cb_wr && hit_dh) begin
				dev_head <= wdata;
			end
		end
	end

	// device control sits behind the alternate status address
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dev_ctrl <= RST_REG;
		end else if (ctl_wr) begin
			dev_ctrl <= wdata;
		end
	end

	// command launch with a snapshot of the parameters
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cmd_start <= 1'b0;
			cmd_code <= RST_REG;
			cmd_cyl_lo <= RST_REG;
			cmd_cyl_hi <= RST_REG;
			cmd_dev_head <= RST_REG;
			cmd_diag_both <= 1'b0;
		end else begin
			cmd_start <= cmd_exec;
			if (cmd_exec) begin
				cmd_code <= wdata;
				cmd_cyl_lo <= cyl_lo;
				cmd_cyl_hi <= cyl_hi;
				cmd_dev_head <= dev_head;
				cmd_diag_both <= diag_both;
			end
		end
	end

	// pending interrupt and the host interrupt pin
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_pend <= 1'b0;
			intrq_out <= 1'b0;
			intrq_oe_n <= 1'b1;
		end else begin
			irq_pend <= next_irq;
			intrq_out <= next_irq;
			intrq_oe_n <= dev_ctrl[NIEN_BIT] || !selected;
		end
	end

	// data bus drive, held for the whole read strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dd_out <= RST_BUS;
			dd_oe_n <= 1'b1;
		end else if (rd_drive) begin
			dd_out <= {RST_REG, rd_byte};
			dd_oe_n <= 1'b0;
		end else if (!pin_if.rd_active) begin
			dd_oe_n <= 1'b1;
		end
	end

	// soft reset, diagnostics line towards device 0
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			soft_reset <= 1'b0;
			pdiag_out_n <= 1'b0;
			pdiag_oe_n <= 1'b1;
			peer_ok_q <= 1'b0;
			peer_diag_ok <= 1'b0;
		end else begin
			soft_reset <= dev_ctrl[SRST_BIT];
			pdiag_out_n <= 1'b0;
			// device 1 pulls the line low to post a pass
			pdiag_oe_n <= !(pin_if.dev_id && fw_diag_pass);
			peer_ok_q <= pin_if.peer_ok;
			peer_diag_ok <= peer_ok_q && !pin_if.dev_id;
		end
	end

	// checks, all on ref_clk
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	AST_INVALID_IDLE:
		assert property (pin_if.rd_pulse && (cs0_n == cs1_n) && dd_oe_n |=> dd_oe_n)
		else $error("bus driven on invalid chip select");
	AST_CTL_ONLY6:
		assert property (pin_if.rd_pulse && blk_ctl && (da != OFF_ALT_STATUS) && dd_oe_n
			|=> dd_oe_n)
		else $error("control block answered off address 6h");
	AST_ALT_READ:
		assert property (rd_alt && selected && !fw_sleep
			|=> !dd_oe_n && (dd_out[7:0] == $past(status_byte)))
		else $error("alternate status differs from status");
	AST_CTL_WRITE:
		assert property (ctl_wr |=> dev_ctrl == $past(wdata))
		else $error("device control write lost");
	AST_ALT_KEEPS_IRQ:
		assert property (rd_alt && !cmd_take && irq_pend |=> irq_pend)
		else $error("alternate status read cleared interrupt");
	AST_STAT_CLEARS:
		assert property (rd_stat && !fw_irq_set |=> !irq_pend)
		else $error("status read left interrupt pending");
	AST_CMD_CLEARS:
		assert property (cmd_take && selected && !fw_irq_set |=> !irq_pend && !intrq_out)
		else $error("command write left interrupt pending");
	AST_CMD_START:
		assert property (cmd_exec |=> cmd_start && (cmd_code == $past(wdata))
			&& (cmd_cyl_lo == $past(cyl_lo)) && busy_flag)
		else $error("command not launched with its parameters");
	AST_BUSY_IGNORE:
		assert property (wr_ok && hit_lo && busy |=> $stable(cyl_lo))
		else $error("cylinder write taken while busy");
	AST_BUSY_HOLD:
		assert property (busy_flag && !fw_param_taken |=> busy_flag)
		else $error("busy dropped before parameters taken");
	AST_UNSEL_NO_EXEC:
		assert property (cmd_take && !selected && !diag_both |=> !cmd_start)
		else $error("unselected drive started a command");
	// register writes land one cycle after the filtered pulse
	AST_CYL_LO_WRITE:
		assert property (cb_wr && hit_lo |=> cyl_lo == $past(wdata))
		else $error("cylinder low write lost");
	AST_CYL_HI_WRITE:
		assert property (cb_wr && hit_hi |=> cyl_hi == $past(wdata))
		else $error("cylinder high write lost");
	AST_DEV_HEAD_WRITE:
		assert property (cb_wr && hit_dh |=> dev_head == $past(wdata))
		else $error("device head write lost");
	// an invalid address leaves every register and the bus alone
	AST_INVALID_WRITE:
		assert property (pin_if.wr_pulse && !addr_ok |=> $stable(cyl_lo) && $stable(cyl_hi)
			&& $stable(dev_head) && $stable(dev_ctrl) && !cmd_start)
		else $error("write taken on invalid address");
	AST_INVALID_READ:
		assert property (pin_if.rd_pulse && !addr_ok && dd_oe_n |=> dd_oe_n)
		else $error("bus driven on invalid address");
	// reads at the command address and while asleep
	AST_STAT_READ:
		assert property (rd_stat && !fw_sleep
			|=> !dd_oe_n && (dd_out[7:0] == $past(status_byte)))
		else $error("command address read did not return status");
	AST_SLEEP_READ:
		assert property (rd_drive && fw_sleep |=> !dd_oe_n && (dd_out == RST_BUS))
		else $error("read in sleep showed register contents");
	// launch rules; refusal while busy keeps a half-taken command out
	AST_SEL_EXEC:
		assert property (cmd_take && selected |=> cmd_start)
		else $error("selected drive did not start a command");
	AST_DIAG_BOTH:
		assert property (cmd_take && diag_both |=> cmd_start && cmd_diag_both)
		else $error("diagnostics not run on both drives");
	AST_BUSY_REFUSE:
		assert property (cmd_wr && busy && !is_reset_cmd |=> !cmd_start)
		else $error("command taken while busy");
	// a firmware request is never lost to a clear in the same cycle
	AST_IRQ_SET:
		assert property (fw_irq_set |=> irq_pend && intrq_out)
		else $error("interrupt request lost");
	// one access per strobe, a double pulse would repeat a command write
	AST_ONE_PULSE:
		assert property (pin_if.rd_pulse || pin_if.wr_pulse
			|=> !pin_if.rd_pulse && !pin_if.wr_pulse)
		else $error("strobe produced more than one access");
	// diagnostics line between the two drives
	AST_PDIAG_POST:
		assert property (pin_if.dev_id && fw_diag_pass |=> !pdiag_oe_n && !pdiag_out_n)
		else $error("device 1 did not post diagnostics pass");
	AST_PEER_SEEN:
		assert property (pin_if.peer_ok ##1 !pin_if.dev_id |=> peer_diag_ok)
		else $error("device 0 missed partner diagnostics pass");
endmodule
`default_nettype wire

/* File: core/atf_pin_sync.sv */
// Purpose: three-stage synchroniser and filter for host strobes and straps
// Assumes: pins are asynchronous to ref_clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module atf_pin_sync (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] raw,
	atf_pins_if.src pins
);
	import atf_pkg::*;
	logic [3:0] s1, s2, s3, stab;
	logic [3:0] agree, next_stab;

	// stage one feeds stage two only
	assign agree = ~(s2 ^ s3);
	assign next_stab = (agree & s3) | (~agree & stab);

	// one access per strobe: pulse only on the filtered assert edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s1 <= SYNC_IDLE;
			s2 <= SYNC_IDLE;
			s3 <= SYNC_IDLE;
			stab <= SYNC_IDLE;
			pins.rd_pulse <= 1'b0;
			pins.wr_pulse <= 1'b0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			stab <= next_stab;
			pins.rd_pulse <= stab[0] & ~next_stab[0];
			pins.wr_pulse <= stab[1] & ~next_stab[1];
		end
	end

	// levels, all from the filtered register
	assign pins.rd_active = ~stab[0];
	assign pins.dev_id = stab[2];
	assign pins.peer_ok = ~stab[3];
endmodule
`default_nettype wire

/* File: core/atf_pins_if.sv */
// Purpose: carries synchronised host pin events to the decode logic
// Assumes: one clock domain, ref_clk
// Notes: pulses last one cycle, levels follow the filtered pins
`timescale 1ns/1ps
`default_nettype none
interface atf_pins_if;
	logic rd_pulse;
	logic wr_pulse;
	logic rd_active;
	logic dev_id;
	logic peer_ok;
	modport src (output rd_pulse, wr_pulse, rd_active, dev_id, peer_ok);
	modport dst (input rd_pulse, wr_pulse, rd_active, dev_id, peer_ok);
endinterface
`default_nettype wire

/* File: core/atf_pkg.sv */
// Purpose: shared constants and types of the task file register decode
// Assumes: chip select field is {cs1_n, cs0_n} taken straight from the pins
// Notes: offsets are the three-bit register address under a chip select
`default_nettype none
package atf_pkg;
	// chip select patterns, raw pin levels
	localparam logic [1:0] CS_CMD = 2'h2;
	localparam logic [1:0] CS_CTL = 2'h1;
	// register offsets
	localparam logic [2:0] OFF_CYL_LO = 3'h4;
	localparam logic [2:0] OFF_CYL_HI = 3'h5;
	localparam logic [2:0] OFF_DEV_HEAD = 3'h6;
	localparam logic [2:0] OFF_ALT_STATUS = 3'h6;
	localparam logic [2:0] OFF_COMMAND = 3'h7;
	// field positions
	localparam int DEV_SEL_BIT = 4;
	localparam int BSY_BIT = 7;
	localparam int DRQ_BIT = 3;
	localparam int SRST_BIT = 2;
	localparam int NIEN_BIT = 1;
	// values after reset
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] RST_BUS = 16'h0000;
	// pin sync order {pdiag_n, strap, diow_n, dior_n}, idle levels
	localparam logic [3:0] SYNC_IDLE = 4'hB;
	typedef enum logic [0:0] {
		ATF_IDLE = 1'b0,
		ATF_HOLD = 1'b1
	} atf_cmd_st_t;
	// true when chip selects and address hit one register
	function automatic logic atf_hit(input logic [1:0] cs, input logic [2:0] da,
		input logic [1:0] want_cs, input logic [2:0] want_da);
		atf_hit = (cs == want_cs) && (da == want_da);
	endfunction
endpackage
`default_nettype wire

/* File: tb/atf_decode_tb.sv */
// Purpose: self-checking bench for the task file register decode
// Assumes: this drive is device 0 until the last test moves the jumper, firmware side driven by the bench
// Notes: random cylinder values and command codes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module atf_decode_tb;
	import atf_pkg::*;
	localparam logic [7:0] DIAG = 8'h90;
	localparam logic [7:0] RSTC = 8'h08;
	logic ref_clk, sys_rst, cs0_n, cs1_n, dior_n, diow_n, dd_oe_n, intrq_out, intrq_oe_n;
	logic pdiag_in_n, fw_irq_set, fw_param_taken, fw_sleep, cmd_start, cmd_diag_both;
	logic soft_reset, peer_diag_ok, g, dev_strap, fw_diag_pass, pdiag_out_n, pdiag_oe_n;
	logic [7:0] cmd_dev_head, l_dh;
	logic [2:0] da;
	logic [15:0] dd_in, dd_out, v;
	logic [7:0] fw_status, cmd_code, cmd_cyl_lo, cmd_cyl_hi, l_code, l_lo, l_hi, lo, hi, code;
	int miscompares = 0, compares = 0, launches = 0, n;
	logic [31:0] seed, r;
	atf_host_model host (.ref_clk(ref_clk), .dd_out(dd_out), .dd_oe_n(dd_oe_n), .cs0_n(cs0_n),
		.cs1_n(cs1_n), .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in));
	atf_decode #(.DIAG_CODE(DIAG), .DEV_RESET_CODE(RSTC)) DUT (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
		.diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
		.dev_strap(dev_strap), .intrq_out(intrq_out), .intrq_oe_n(intrq_oe_n),
		.pdiag_in_n(pdiag_in_n), .pdiag_out_n(pdiag_out_n), .pdiag_oe_n(pdiag_oe_n),
		.fw_status(fw_status), .fw_irq_set(fw_irq_set), .fw_param_taken(fw_param_taken),
		.fw_sleep(fw_sleep), .fw_diag_pass(fw_diag_pass),
		.cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_cyl_lo(cmd_cyl_lo),
		.cmd_cyl_hi(cmd_cyl_hi), .cmd_dev_head(cmd_dev_head), .cmd_diag_both(cmd_diag_both),
		.soft_reset(soft_reset), .peer_diag_ok(peer_diag_ok));
	// 125 MHz
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// snapshot of each launch, seen one edge after it is raised
	always @(posedge ref_clk) begin
		if (cmd_start === 1'b1) begin
			launches++;
			l_code = cmd_code;
			l_lo = cmd_cyl_lo;
			l_hi = cmd_cyl_hi;
			l_dh = cmd_dev_head;
		end
	end
	function automatic logic [15:0] exp_st(input logic [7:0] fw, input logic busy);
		exp_st = {8'h00, fw[7] | busy, fw[6:0]};
	endfunction
	task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic chk_flag(input string what, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", what, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d);
		host.access(cs, a, 1'b1, d, g, v);
	endtask
	task automatic rd(input string what, input logic [1:0] cs, input logic [2:0] a,
		input logic eg, input logic [15:0] ev);
		host.access(cs, a, 1'b0, 8'h00, g, v);
		chk_flag(what, eg, g);
		if (eg) chk_val(what, ev, v);
	endtask
	task automatic pulse_taken();
		@(posedge ref_clk);
		#1 fw_param_taken = 1'b1;
		@(posedge ref_clk);
		#1 fw_param_taken = 1'b0;
	endtask
	task automatic pulse_irq();
		@(posedge ref_clk);
		#1 fw_irq_set = 1'b1;
		@(posedge ref_clk);
		#1 fw_irq_set = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic complete_run();
		$display("counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		#(8 * 40000);
		miscompares++;
		complete_run();
	end
	initial begin
		seed = 32'hBBDE2DB5;
		{sys_rst, pdiag_in_n} = 2'h3;
		{fw_irq_set, fw_param_taken, fw_sleep, fw_diag_pass, dev_strap} = 5'h00;
		fw_status = 8'h50;
		repeat (8) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		chk_flag("dd_oe_n reset", 1'b1, dd_oe_n);
		chk_flag("intrq reset", 1'b0, intrq_out);
		chk_flag("pdiag oe reset", 1'b1, pdiag_oe_n);
		$display("test reset done");
		// host writes cylinder and command registers without first polling busy or drq
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			{lo, hi, code} = {r[7:0], r[15:8], r[23:17], 1'b1};
			wr(CS_CMD, OFF_CYL_LO, lo);
			wr(CS_CMD, OFF_CYL_HI, hi);
			wr(CS_CMD, OFF_DEV_HEAD, 8'hA0);
			n = launches;
			wr(CS_CMD, OFF_COMMAND, code);
			chk_val("launch count", n + 1, launches);
			chk_val("cmd code", code, l_code);
			chk_val("cmd cyl lo", lo, l_lo);
			chk_val("cmd cyl hi", hi, l_hi);
			chk_val("cmd dev head", 8'hA0, l_dh);
			rd("alt busy", CS_CTL, OFF_ALT_STATUS, 1'b1, exp_st(fw_status, 1'b1));
			// odd code, never the reset code: must be refused while busy
			wr(CS_CMD, OFF_COMMAND, code ^ 8'h02);
			chk_val("busy refuse", n + 1, launches);
			wr(CS_CMD, OFF_CYL_LO, ~lo);
			pulse_taken();
			rd("cyl lo", CS_CMD, OFF_CYL_LO, 1'b1, {8'h00, lo});
			rd("cyl hi", CS_CMD, OFF_CYL_HI, 1'b1, {8'h00, hi});
			rd("alt idle", CS_CTL, OFF_ALT_STATUS, 1'b1, exp_st(fw_status, 1'b0));
		end
		$display("test launch done");
		pulse_irq();
		chk_flag("irq set", 1'b1, intrq_out);
		rd("alt st", CS_CTL, OFF_ALT_STATUS, 1'b1, exp_st(fw_status, 1'b0));
		chk_flag("irq after alt", 1'b1, intrq_out);
		rd("status", CS_CMD, OFF_COMMAND, 1'b1, exp_st(fw_status, 1'b0));
		chk_flag("irq after status", 1'b0, intrq_out);
		pulse_irq();
		wr(CS_CMD, OFF_COMMAND, code);
		chk_flag("irq after cmd", 1'b0, intrq_out);
		pulse_taken();
		$display("test interrupt done");
		// both selects equal, and control block off 6h, are invalid
		for (int i = 0; i < 3; i++) begin
			wr(i == 2 ? CS_CTL : 2'(i * 3), OFF_CYL_LO, 8'h04);
			rd("invalid", i == 2 ? CS_CTL : 2'(i * 3), OFF_CYL_LO, 1'b0, 16'h0000);
		end
		rd("cyl lo kept", CS_CMD, OFF_CYL_LO, 1'b1, {8'h00, lo});
		chk_flag("srst kept", 1'b0, soft_reset);
		wr(CS_CTL, OFF_ALT_STATUS, 8'h06);
		chk_flag("srst", 1'b1, soft_reset);
		chk_flag("intrq oe", 1'b1, intrq_oe_n);
		wr(CS_CTL, OFF_ALT_STATUS, 8'h00);
		chk_flag("srst off", 1'b0, soft_reset);
		chk_flag("intrq oe on", 1'b0, intrq_oe_n);
		$display("test decode done");
		fw_status = 8'hD0;
		n = launches;
		wr(CS_CMD, OFF_CYL_HI, ~hi);
		wr(CS_CMD, OFF_COMMAND, RSTC);
		chk_val("reset launch", n + 1, launches);
		chk_val("reset code", RSTC, l_code);
		fw_status = 8'h50;
		pulse_taken();
		rd("cyl hi kept", CS_CMD, OFF_CYL_HI, 1'b1, {8'h00, hi});
		wr(CS_CMD, OFF_DEV_HEAD, 8'hB0);
		rd("unselected", CS_CMD, OFF_COMMAND, 1'b0, 16'h0000);
		chk_flag("intrq oe other", 1'b1, intrq_oe_n);
		n = launches;
		wr(CS_CMD, OFF_COMMAND, code);
		chk_val("other launch", n, launches);
		pulse_taken();
		wr(CS_CMD, OFF_DEV_HEAD, 8'hA0);
		wr(CS_CMD, OFF_COMMAND, DIAG);
		chk_val("diag launch", n + 1, launches);
		chk_flag("diag both", 1'b1, cmd_diag_both);
		@(posedge ref_clk);
		#1 pdiag_in_n = 1'b0;
		fw_diag_pass = 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk_flag("peer diag", 1'b1, peer_diag_ok);
		chk_flag("dev0 pdiag off", 1'b1, pdiag_oe_n);
		pulse_taken();
		$display("test select done");
		fw_sleep = 1'b1;
		rd("sleep", CS_CTL, OFF_ALT_STATUS, 1'b1, 16'h0000);
		fw_sleep = 1'b0;
		$display("test sleep done");
		// jumper moved: this drive now answers as device 1
		dev_strap = 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk_flag("pdiag drive", 1'b0, pdiag_oe_n);
		chk_flag("pdiag level", 1'b0, pdiag_out_n);
		chk_flag("peer as dev1", 1'b0, peer_diag_ok);
		rd("dev1 unselected", CS_CMD, OFF_COMMAND, 1'b0, 16'h0000);
		$display("test device 1 done");
		complete_run();
	end
endmodule
`default_nettype wire

/* File: tb/atf_host_model.sv */
// Purpose: host bus controller model driving chip selects, address and strobes
// Assumes: one access at a time, strobes held long enough for the device filter
// Notes: released data and address lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module atf_host_model (
	input wire logic ref_clk,
	input wire logic [15:0] dd_out,
	input wire logic dd_oe_n,
	output logic cs0_n,
	output logic cs1_n,
	output logic [2:0] da,
	output logic dior_n,
	output logic diow_n,
	output logic [15:0] dd_in
);
	// idle bus: no chip select, no strobe
	initial begin
		cs0_n = 1'b1;
		cs1_n = 1'b1;
		da = 3'h0;
		dior_n = 1'b1;
		diow_n = 1'b1;
		dd_in = 16'hFFFF;
	end
	// address set up one cycle ahead, held six cycles past the strobe so the sync sees it
	task automatic access(input logic [1:0] cs, input logic [2:0] a, input logic wr,
		input logic [7:0] wd, output logic got, output logic [15:0] rv);
		got = 1'b0;
		rv = 16'h0000;
		@(posedge ref_clk);
		#1 {cs1_n, cs0_n} = cs;
		da = a;
		dd_in = {8'h00, wd};
		@(posedge ref_clk);
		#1 if (wr) diow_n = 1'b0;
		else dior_n = 1'b0;
		// sample after the edge so registered outputs have settled
		repeat (7) begin
			@(posedge ref_clk);
			#1 if (dd_oe_n === 1'b0) begin
				got = 1'b1;
				rv = dd_out;
			end
		end
		dior_n = 1'b1;
		diow_n = 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 {cs1_n, cs0_n} = 2'h3;
		da = ~a;
		dd_in = ~dd_in;
	endtask
endmodule
`default_nettype wire
